//--- hdl/cmsw_status.v
`timescale 1ns/1ps
`default_nettype none
`include "cmsw_regs.vh"
// =====================================
// Function
// (RQ1) fixed 32-bit io word, reserved zero
// (RQ2) low twelve bits sample inputs
// (RQ3) bits 15-18 show real output levels
// (RQ4) bits 24-27 flag output short faults
// (RQ5) health bit 0 set when ready
// (RQ6) ready clears unconfigured, absent, fatal
// (RQ7) health bit 2 shows field power
// (RQ8) health bit 4 flags command error
// (RQ9) bits 16-31 hold error description
// (RQ10) host writes clear-error to acknowledge
// (RQ11) keep first description until acknowledged
// (RQ12) fatal: no code, watchdog, blink indicator
// (RQ13) description: code, counter, source fields
// (RQ14) acknowledge clears flag and description
module cmsw_status #(
  parameter BLINK_CYC = `CMSW_BLINK_CYC
) (
  input  wire        clk,
  input  wire        rstn,
  input  wire        io_service,
  input  wire [11:0] ext_inputs,
  input  wire [3:0]  ext_outputs,
  input  wire [3:0]  output_short_circuit_fault,
  input  wire        configured,
  input  wire        present,
  input  wire        init_done,
  input  wire        fatal_mem_error,
  input  wire        field_power,
  input  wire        err_pulse,
  input  wire [7:0]  err_code,
  input  wire [3:0]  err_counter,
  input  wire [3:0]  err_source,
  input  wire        clear_error,
  output reg  [31:0] io_point_status_word,
  output reg  [31:0] module_health_word,
  output reg         failure_mode,
  output reg         watchdog_expired,
  output reg         status_led
);
  // =====================================
  // field positions
  localparam IN_LSB   = `CMSW_IO_IN_LSB;
  localparam IN_W     = `CMSW_IO_IN_W;
  localparam OUT_LSB  = `CMSW_IO_OUT_LSB;
  localparam OUT_W    = `CMSW_IO_OUT_W;
  localparam FLT_LSB  = `CMSW_IO_FLT_LSB;
  localparam FLT_W    = `CMSW_IO_FLT_W;
  localparam RDY_BIT  = `CMSW_MH_READY_BIT;
  localparam FPWR_BIT = `CMSW_MH_FPWR_BIT;
  localparam CERR_BIT = `CMSW_MH_CERR_BIT;
  localparam DESC_LSB = `CMSW_MH_DESC_LSB;
  localparam DESC_W   = `CMSW_MH_DESC_W;

  // =====================================
  // operating mode
  localparam [0:0] MODE_RUN  = 1'b0;
  localparam [0:0] MODE_FAIL = 1'b1;

  // =====================================
  // field placement
  // masks to the field width first, so a wide source cannot spill
  // into a neighbouring field or a reserved bit
  function [31:0] cmsw_place;
    input [31:0]  field;
    input integer lsb;
    input integer width;
    reg   [31:0]  mask;
    begin
      mask       = (32'h0000_0001 << width) - 32'h0000_0001;
      cmsw_place = (field & mask) << lsb;
    end
  endfunction

  // =====================================
  // error capture
  wire        cmd_err;
  wire [15:0] err_desc;
  reg         err_gated;

  // a fatal fault never logs a code, and a failed module logs nothing more
  always @* begin
    err_gated = err_pulse;
    if (fatal_mem_error || failure_mode) begin
      err_gated = 1'b0;                                              // RQ12
    end
  end

  // the latch keeps the first error until the host acknowledges it
  cmsw_err_latch u_err (
    .clk          (clk),
    .rstn         (rstn),
    .err_pulse    (err_gated),
    .err_code     (err_code),
    .err_counter  (err_counter),
    .err_source   (err_source),
    .clear_error  (clear_error),      // RQ10
    .cmd_err_reg  (cmd_err),
    .err_desc_reg (err_desc)
  );

  // =====================================
  // failure mode
  reg mode_next;

  // only a restart leaves failure mode; the host has no way out of it
  always @* begin
    mode_next = failure_mode;
    case (failure_mode)
      MODE_RUN: begin
        if (fatal_mem_error) begin
          mode_next = MODE_FAIL;                                     // RQ12
        end
      end
      MODE_FAIL: begin
        mode_next = MODE_FAIL;
      end
      default: begin
        mode_next = MODE_FAIL;
      end
    endcase
  end

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      failure_mode     <= MODE_RUN;
      watchdog_expired <= 1'b0;
    end else begin
      failure_mode <= mode_next;                                     // RQ12
      if (mode_next == MODE_FAIL) begin
        // a failed module stops servicing its watchdog
        watchdog_expired <= 1'b1;                                    // RQ12
      end
    end
  end

  // =====================================
  // indicator blink divider
  reg  [31:0] blink_cnt_reg;
  wire        blink_tick;

  // one-cycle enable at the end of each half period
  assign blink_tick = (mode_next == MODE_FAIL) && (blink_cnt_reg >= BLINK_CYC - 1);

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      blink_cnt_reg <= 32'h0000_0000;
    end else if (mode_next != MODE_FAIL || blink_tick) begin
      blink_cnt_reg <= 32'h0000_0000;
    end else begin
      blink_cnt_reg <= blink_cnt_reg + 32'h0000_0001;
    end
  end

  // =====================================
  // status indicator
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      status_led <= 1'b0;
    end else if (mode_next == MODE_FAIL) begin
      if (blink_tick) begin
        status_led <= ~status_led;                                   // RQ12
      end
    end else begin
      status_led <= configured & present & init_done;
    end
  end

  // =====================================
  // io word
  // inputs are synchronous to clk, so they are placed as they stand
  wire [31:0] io_in_field  = cmsw_place({20'h0_0000, ext_inputs}, IN_LSB, IN_W);                    // RQ2
  wire [31:0] io_out_field = cmsw_place({28'h000_0000, ext_outputs}, OUT_LSB, OUT_W);               // RQ3
  wire [31:0] io_flt_field = cmsw_place({28'h000_0000, output_short_circuit_fault}, FLT_LSB, FLT_W); // RQ4
  reg  [31:0] io_word_next;

  // reserved positions are never placed, so they read zero
  always @* begin
    io_word_next = io_in_field | io_out_field | io_flt_field;       // RQ1
  end

  // refreshed only on an io service: the host sees the levels of that moment
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      io_point_status_word <= `CMSW_WORD_RST;
    end else if (io_service) begin
      io_point_status_word <= io_word_next;                          // RQ2 RQ3 RQ4
    end
  end

  // =====================================
  // health word
  reg         ready;
  wire [31:0] mh_ready_field = cmsw_place({31'h0, ready}, RDY_BIT, 1);          // RQ5
  wire [31:0] mh_fpwr_field  = cmsw_place({31'h0, field_power}, FPWR_BIT, 1);   // RQ7
  wire [31:0] mh_cerr_field  = cmsw_place({31'h0, cmd_err}, CERR_BIT, 1);       // RQ8
  wire [31:0] mh_desc_field  = cmsw_place({16'h0000, err_desc}, DESC_LSB, DESC_W);   // RQ9
  reg  [31:0] health_word_next;

  // any missing condition or a fatal fault takes ready away
  always @* begin
    ready = 1'b0;
    if (configured && present && init_done && !fatal_mem_error && failure_mode == MODE_RUN) begin
      ready = 1'b1;                                                  // RQ5 RQ6
    end
  end

  always @* begin
    health_word_next = mh_ready_field | mh_fpwr_field | mh_cerr_field | mh_desc_field;
  end

  // rebuilt every cycle so ready and field power follow within one clock
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      module_health_word <= `CMSW_WORD_RST;
    end else begin
      module_health_word <= health_word_next;                        // RQ5 RQ7 RQ8 RQ9
    end
  end
endmodule
`default_nettype wire

//--- hdl/cmsw_regs.vh
`ifndef CMSW_REGS_VH
`define CMSW_REGS_VH
// =====================================
// io point status word layout
`define CMSW_IO_IN_LSB      0
`define CMSW_IO_IN_W        12
`define CMSW_IO_OUT_LSB     15
`define CMSW_IO_OUT_W       4
`define CMSW_IO_FLT_LSB     24
`define CMSW_IO_FLT_W       4
// =====================================
// module health word layout
`define CMSW_MH_READY_BIT   0
`define CMSW_MH_FPWR_BIT    2
`define CMSW_MH_CERR_BIT    4
`define CMSW_MH_DESC_LSB    16
`define CMSW_MH_DESC_W      16
// =====================================
// error description fields
`define CMSW_ED_CODE_LSB    0
`define CMSW_ED_CODE_W      8
`define CMSW_ED_CNT_LSB     8
`define CMSW_ED_CNT_W       4
`define CMSW_ED_SRC_LSB     12
`define CMSW_ED_SRC_W       4
// =====================================
// reset values
`define CMSW_WORD_RST       32'h0000_0000
`define CMSW_DESC_RST       16'h0000
// =====================================
// failure indicator blink half period
`define CMSW_BLINK_NS       250000000
`define CMSW_CLK_NS         10
`define CMSW_BLINK_CYC      (`CMSW_BLINK_NS / `CMSW_CLK_NS)
`endif

//--- hdl/cmsw_err_latch.v
`timescale 1ns/1ps
`default_nettype none
`include "cmsw_regs.vh"
// =====================================
// first-error capture, held until acknowledged
module cmsw_err_latch (
  input  wire        clk,
  input  wire        rstn,
  input  wire        err_pulse,
  input  wire [7:0]  err_code,
  input  wire [3:0]  err_counter,
  input  wire [3:0]  err_source,
  input  wire        clear_error,
  output reg         cmd_err_reg,
  output reg  [15:0] err_desc_reg
);
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cmd_err_reg  <= 1'b0;
      err_desc_reg <= `CMSW_DESC_RST;
    end else if (err_pulse && (!cmd_err_reg || clear_error)) begin   // RQ11
      // logged and unacknowledged: later errors are ignored;
      // a new error in the acknowledge cycle still lands
      cmd_err_reg  <= 1'b1;                                  // RQ8
      err_desc_reg <= {err_source, err_counter, err_code};   // RQ9 RQ13
    end else if (clear_error) begin
      cmd_err_reg  <= 1'b0;                                  // RQ14
      err_desc_reg <= `CMSW_DESC_RST;                        // RQ14
    end
  end
endmodule
`default_nettype wire

//--- dv/cmsw_props_properties.sv
`timescale 1ns/1ps
`default_nettype none
module cmsw_props (
  input wire logic        clk,
  input wire logic        rstn,
  input wire logic        io_service,
  input wire logic        fatal_mem_error,
  input wire logic        err_pulse,
  input wire logic        clear_error,
  input wire logic        failure_mode,
  input wire logic [31:0] io_point_status_word,
  input wire logic [31:0] module_health_word
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  wire logic [31:0] io = io_point_status_word;
  wire logic [31:0] mh = module_health_word;
  io_rsvd_a: assert property ((io & 32'hf0f8_7000) == 32'h0) else $error("io reserved set");
  io_hold_a: assert property (!io_service |=> $stable(io)) else $error("io word moved");
  mh_rsvd_a: assert property ((mh & 32'h0000_ffea) == 32'h0) else $error("health reserved set");
  fatal_fail_a: assert property (fatal_mem_error |=> failure_mode && !mh[0]) else $error("fatal ignored");
  fail_sticky_a: assert property (failure_mode |=> failure_mode) else $error("failure left");
  fail_nolog_a: assert property (failure_mode && !mh[4] |=> !mh[4]) else $error("code logged in failure");
  err_keep_a: assert property (mh[4] && !$past(clear_error) |=> mh[4] && $stable(mh[31:16])) else $error("lost");
  err_clear_a: assert property (clear_error && !err_pulse |-> ##2 mh[31:16] == 16'h0 && !mh[4]) else $error("kept");
  err_cause_a: assert property ($rose(mh[4]) |-> $past(err_pulse, 2)) else $error("error without pulse");
  cover property (io_service);
  cover property (clear_error && mh[4]);
  cover property (err_pulse && clear_error && mh[4]);
  cover property (fatal_mem_error);
endmodule
bind cmsw_status cmsw_props u_props (.*);
`default_nettype wire

//--- dv/cmsw_host.sv
`timescale 1ns/1ps
`default_nettype none
module cmsw_host (
  input  wire logic        clk,
  input  wire logic        ack,
  input  wire logic [31:0] module_health_word,
  output var  logic        clear_error
);
  // acks only a logged error, as a host would once the cause is fixed
  always @(posedge clk) clear_error <= ack && module_health_word[4];
endmodule
`default_nettype wire

//--- dv/counter_module_status_words_test.sv
`timescale 1ns/1ps
`default_nettype none
module counter_module_status_words_test;
  logic clk = 1'h0, rstn = 1'h0, io_service = 1'h0, configured = 1'h1, present = 1'h1, init_done = 1'h1;
  logic fatal_mem_error = 1'h0, field_power = 1'h1, err_pulse = 1'h0, ack = 1'h0, l;
  logic clear_error, failure_mode, watchdog_expired, status_led;
  logic [11:0] ext_inputs = 12'h0;
  logic [7:0] err_code = 8'h0;
  logic [3:0] ext_outputs = 4'h0, output_short_circuit_fault = 4'h0, err_counter = 4'h0, err_source = 4'h0;
  logic [31:0] io_point_status_word, module_health_word;
  int n_errors = 0, tests_run = 0;
  always #5 clk = ~clk;
  cmsw_status #(.BLINK_CYC(4)) i_dut (.*);
  cmsw_host i_host (.clk(clk), .ack(ack), .module_health_word(module_health_word), .clear_error(clear_error));
  task chk(input logic [31:0] got, exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: %h", $time, got);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task summarize;
    if (n_errors == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    cyc(6);
    rstn = 1'h1;
    {io_service, ext_inputs, ext_outputs, output_short_circuit_fault} = 21'h1f_ffff;
    cyc(1);
    chk(module_health_word, 32'h5);
    // inputs move without service: word must hold
    {io_service, ext_inputs, ext_outputs, output_short_circuit_fault} = 21'h0_5a35a;
    cyc(1);
    chk(io_point_status_word, 32'h0f07_8fff);
    io_service = 1'h1;
    {field_power, configured} = 2'h0;
    cyc(1);
    chk(io_point_status_word, 32'h0a02_85a3);
    chk(module_health_word, 32'h0);
    {io_service, field_power, configured, present} = 4'h6;
    {err_pulse, err_source, err_counter, err_code} = 17'h1_2408;
    cyc(1);
    chk(module_health_word, 32'h4);
    present = 1'h1;
    {err_source, err_counter, err_code} = 16'h1101;
    cyc(1);
    err_pulse = 1'h0;
    cyc(2);
    chk(module_health_word, 32'h2408_0015);
    ack = 1'h1;
    cyc(1);
    ack = 1'h0;
    cyc(3);
    chk(module_health_word, 32'h5);
    {err_pulse, err_source, err_counter, err_code} = 17'h1_1101;
    cyc(1);
    err_pulse = 1'h0;
    cyc(1);
    chk(module_health_word, 32'h1101_0015);
    ack = 1'h1;
    cyc(1);
    // new error in the acknowledge cycle: the set wins
    {ack, err_pulse, err_source, err_counter, err_code} = 18'h1_3002;
    cyc(1);
    err_pulse = 1'h0;
    cyc(2);
    chk(module_health_word, 32'h3002_0015);
    ack = 1'h1;
    cyc(1);
    {ack, fatal_mem_error} = 2'h1;
    cyc(1);
    l = status_led;
    {err_pulse, err_source, err_counter, err_code} = 17'h1_1103;
    cyc(1);
    err_pulse = 1'h0;
    cyc(2);
    chk(module_health_word, 32'h4);
    chk({failure_mode, watchdog_expired, module_health_word[0], status_led ^ l}, 4'hd);
    summarize;
  end
  initial begin
    #2000;
    n_errors++;
    summarize;
  end
endmodule
`default_nettype wire
